// *** pst_stage.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pst_consts.svh"

// Notes on behaviour
// - Release below 97 percent of pick-up setting
// - Compare setting and magnitude every cycle
// - Sample blocking input at cycle start
// - Pick-up unblocked asserts start, begins timing
// - Pick-up while blocked asserts blocked only
// - Blocking clears start and resets operate timing
// - Blocking logs time-stamped event with values
// - Instant mode trips together with start
// - Definite mode trips after fixed delay
// - Inverse mode delay from setting, magnitude
// - Inverse never trips before minimum delay
// - Delay type selectable, definite by default
// - Zero definite delay means instant operation
// - Curve series selectable, IEC by default
// - Output forcing only when forcing enabled
module pst_stage
    import pst_pkg::*;
#(
    parameter int MAG_W       = 16,
    parameter int DLY_W       = 21,
    parameter int TICK_CYCLES = `PST_CYCLE_TIME_NS / `PST_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    // Measurement front end and blocking matrix
    input  wire logic [MAG_W-1:0] measured_magnitude,
    input  wire logic [3:0]       fault_type,
    input  wire logic             block_in,
    // Stage outputs
    output logic                  start_o,
    output logic                  trip_o,
    output logic                  blocked_o,
    output logic                  irq_o,
    // Blocking event record
    output logic                  evt_valid_o,
    output logic      [31:0]      evt_time_o,
    output logic      [MAG_W-1:0] evt_mag_o,
    output logic      [3:0]       evt_fault_o
);

    // ****************************************
    // Local constants
    // ****************************************
    localparam int TW    = $clog2(TICK_CYCLES);
    localparam int PW    = MAG_W + 7;
    localparam int AW    = 2 * MAG_W + 8;
    localparam logic [TW-1:0]    TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [DLY_W-1:0] DLY_MAX   = {DLY_W{1'b1}};

    // ****************************************
    // Declarations
    // ****************************************
    logic [TW-1:0]       tick_cnt_q;
    logic                tick_q;
    logic                eval_q;
    logic [31:0]         time_q;
    logic [MAG_W-1:0]    meas_s_q;
    logic [3:0]          fault_s_q;
    logic                blk_s_q;
    logic [`PST_CTRL_W-1:0] ctrl_q;
    logic [MAG_W-1:0]    pickup_setting_q;
    logic [DLY_W-1:0]    delay_q;
    logic [MAG_W-1:0]    tdial_q;
    logic [`PST_ST_W-1:0] status_q;
    logic [`PST_ST_W-1:0] mask_q;
    logic [`PST_ST_W-1:0] st_set;
    pst_state_t          state_q;
    logic                pick_q;
    logic                pick_d;
    logic                trip_q;
    logic [DLY_W-1:0]    dt_cnt_q;
    logic [DLY_W-1:0]    dt_cnt_next;
    logic [AW-1:0]       acc_q;
    logic [AW-1:0]       acc_next;
    logic [MAG_W-1:0]    inc;
    logic [AW-1:0]       thr;
    logic                go_start;
    logic                go_block;
    logic                dt_done;
    logic                inv_done;
    logic                blk_event;
    logic                definite_delay_mode;
    logic                inverse_minimum_delay_mode;
    logic                iec_series;
    logic [PW-1:0]       meas_pct;
    logic [PW-1:0]       hold_pct;

    assign definite_delay_mode        = (ctrl_q[`PST_CTRL_DTYPE] == PST_DEFINITE);
    assign inverse_minimum_delay_mode = (ctrl_q[`PST_CTRL_DTYPE] == PST_INVERSE);
    assign iec_series                 = (ctrl_q[`PST_CTRL_SERIES] == PST_SER_IEC);

    // ****************************************
    // Processing cycle divider
    // ****************************************
    // One tick per processing cycle; eval follows so sampled values settle first
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
            eval_q     <= 1'b0;
        end else begin
            tick_q     <= (tick_cnt_q == TICK_LAST);
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
            eval_q     <= tick_q;
        end
    end

    // Millisecond time stamp for the event record
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            time_q <= '0;
        end else if (tick_q) begin
            time_q <= time_q + 32'h0000_0001;
        end
    end

    // ****************************************
    // Input sampling
    // ****************************************
    // Blocking is looked at once per cycle, so a source must lead the trip by a margin
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meas_s_q  <= '0;
            fault_s_q <= '0;
            blk_s_q   <= 1'b0;
        end else if (tick_q) begin
            meas_s_q  <= measured_magnitude;
            fault_s_q <= fault_type;
            blk_s_q   <= block_in;
        end
    end

    // ****************************************
    // Pick-up element
    // ****************************************
    // Cross products avoid a divider: m*100 against set*97
    assign meas_pct = PW'(meas_s_q) * PW'(`PST_FULL_PCT);
    assign hold_pct = PW'(pickup_setting_q) * PW'(`PST_RESET_PCT);
    always_comb begin
        if (pick_q) begin
            pick_d = (meas_pct >= hold_pct);
        end else begin
            pick_d = (meas_s_q > pickup_setting_q);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pick_q <= 1'b0;
        end else if (eval_q) begin
            pick_q <= pick_d;
        end
    end

    // ****************************************
    // Operating delay arithmetic
    // ****************************************
    // Inverse curve as a running integral: IEC integrates m, IEEE integrates m-set
    always_comb begin
        if (iec_series) begin
            inc = meas_s_q;
        end else if (meas_s_q > pickup_setting_q) begin
            inc = meas_s_q - pickup_setting_q;
        end else begin
            inc = '0;
        end
    end
    assign thr         = AW'(tdial_q) * AW'(pickup_setting_q);
    assign acc_next    = acc_q + AW'(inc);
    assign dt_cnt_next = (dt_cnt_q == DLY_MAX) ? dt_cnt_q : dt_cnt_q + 1'b1;
    assign dt_done     = (dt_cnt_next >= delay_q);
    assign inv_done    = (acc_next >= thr) && (dt_cnt_next >= delay_q);
    assign go_start    = eval_q && (state_q == PST_IDLE) && pick_d && !blk_s_q;
    assign go_block    = eval_q && pick_d && blk_s_q && (state_q != PST_BLOCKED);
    assign blk_event   = go_block;

    // ****************************************
    // Stage state machine
    // ****************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= PST_IDLE;
            trip_q   <= 1'b0;
            dt_cnt_q <= '0;
            acc_q    <= '0;
        end else if (eval_q) begin
            unique case (state_q)
                PST_IDLE: begin
                    if (pick_d && blk_s_q) begin
                        state_q <= PST_BLOCKED;
                    end else if (pick_d) begin
                        state_q  <= PST_STARTED;
                        dt_cnt_q <= {{(DLY_W-1){1'b0}}, 1'b1};
                        acc_q    <= AW'(inc);
                        trip_q   <= definite_delay_mode && (delay_q == '0);
                    end
                end
                PST_STARTED: begin
                    if (!pick_d || blk_s_q) begin
                        // Drop-out and blocking share one release path
                        state_q  <= blk_s_q && pick_d ? PST_BLOCKED : PST_IDLE;
                        trip_q   <= 1'b0;
                        dt_cnt_q <= '0;
                        acc_q    <= '0;
                    end else begin
                        dt_cnt_q <= dt_cnt_next;
                        if (inverse_minimum_delay_mode) begin
                            acc_q <= (acc_next >= thr) ? thr : acc_next;
                            if (inv_done) begin
                                trip_q <= 1'b1;
                            end
                        end else if (dt_done) begin
                            trip_q <= 1'b1;
                        end
                    end
                end
                PST_BLOCKED: begin
                    // Leave once either cause is gone; a fresh start is judged next cycle
                    if (!pick_d || !blk_s_q) begin
                        state_q <= PST_IDLE;
                    end
                end
                default: begin
                    state_q <= PST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Blocking event record
    // ****************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_valid_o <= 1'b0;
            evt_time_o  <= '0;
            evt_mag_o   <= '0;
            evt_fault_o <= '0;
        end else begin
            evt_valid_o <= blk_event;
            if (blk_event) begin
                evt_time_o  <= time_q;
                evt_mag_o   <= meas_s_q;
                evt_fault_o <= fault_s_q;
            end
        end
    end

    // ****************************************
    // Stage outputs with forcing
    // ****************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_o   <= 1'b0;
            trip_o    <= 1'b0;
            blocked_o <= 1'b0;
        end else if (ctrl_q[`PST_CTRL_FORCE_EN]) begin
            start_o   <= ctrl_q[`PST_CTRL_F_START];
            trip_o    <= ctrl_q[`PST_CTRL_F_TRIP];
            blocked_o <= ctrl_q[`PST_CTRL_F_BLOCK];
        end else begin
            start_o   <= (state_q == PST_STARTED);
            trip_o    <= trip_q;
            blocked_o <= (state_q == PST_BLOCKED);
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q           <= `PST_CTRL_RST;
            pickup_setting_q <= '0;
            delay_q          <= '0;
            tdial_q          <= '0;
            mask_q           <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `PST_ADDR_CTRL:   ctrl_q           <= reg_wdata[`PST_CTRL_W-1:0];
                `PST_ADDR_PICKUP: pickup_setting_q <= reg_wdata[MAG_W-1:0];
                `PST_ADDR_DELAY:  delay_q          <= reg_wdata[DLY_W-1:0];
                `PST_ADDR_TDIAL:  tdial_q          <= reg_wdata[MAG_W-1:0];
                `PST_ADDR_MASK:   mask_q           <= reg_wdata[`PST_ST_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    assign st_set[`PST_ST_START] = go_start;
    // Instant operation trips at the start evaluation, so it must raise the trip event too
    assign st_set[`PST_ST_TRIP]  = eval_q && !trip_q && (state_q == PST_STARTED) && pick_d && !blk_s_q &&
                                   (inverse_minimum_delay_mode ? inv_done : dt_done) ||
                                   (go_start && definite_delay_mode && (delay_q == '0));
    assign st_set[`PST_ST_BLOCK] = blk_event;

    // Read clears, but an event in the same cycle still lands
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= '0;
            irq_o    <= 1'b0;
        end else begin
            if (reg_rd && (reg_addr == `PST_ADDR_STATUS)) begin
                status_q <= st_set;
            end else begin
                status_q <= status_q | st_set;
            end
            irq_o <= |(status_q & mask_q);
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `PST_ADDR_CTRL:   reg_rdata <= 32'(ctrl_q);
                `PST_ADDR_PICKUP: reg_rdata <= 32'(pickup_setting_q);
                `PST_ADDR_DELAY:  reg_rdata <= 32'(delay_q);
                `PST_ADDR_TDIAL:  reg_rdata <= 32'(tdial_q);
                `PST_ADDR_STATUS: reg_rdata <= 32'(status_q);
                `PST_ADDR_MASK:   reg_rdata <= 32'(mask_q);
                `PST_ADDR_STATE:  reg_rdata <= 32'({meas_s_q, 12'h000, blk_s_q, trip_q, state_q});
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    reset_ratio_a: assert property (
        eval_q && state_q == PST_STARTED && meas_pct >= hold_pct && !blk_s_q |=> state_q == PST_STARTED)
        else $error("stage released above reset ratio");

    pickup_level_a: assert property (
        eval_q && state_q == PST_IDLE && meas_s_q <= pickup_setting_q |=> state_q == PST_IDLE)
        else $error("stage started at or below setting");

    block_sample_a: assert property (
        tick_q |=> blk_s_q == $past(block_in))
        else $error("blocking input not sampled on tick");

    start_entry_a: assert property (
        go_start |=> state_q == PST_STARTED ##2 (start_o || ctrl_q[`PST_CTRL_FORCE_EN]))
        else $error("start not raised on unblocked pick-up");

    blocked_entry_a: assert property (
        eval_q && state_q == PST_IDLE && pick_d && blk_s_q |=> state_q == PST_BLOCKED && !trip_q)
        else $error("blocked pick-up not held off");

    block_clears_a: assert property (
        eval_q && state_q == PST_STARTED && blk_s_q |=> state_q != PST_STARTED && acc_q == '0 && !trip_q)
        else $error("blocking did not clear start");

    block_event_a: assert property (
        blk_event |=> evt_valid_o && evt_mag_o == $past(meas_s_q) && evt_fault_o == $past(fault_s_q))
        else $error("blocking event record wrong");

    instant_trip_a: assert property (
        go_start && definite_delay_mode && delay_q == '0 |=> trip_q && state_q == PST_STARTED)
        else $error("instant mode did not trip with start");

    definite_trip_a: assert property (
        eval_q && state_q == PST_STARTED && pick_d && !blk_s_q && definite_delay_mode && dt_done |=> trip_q)
        else $error("definite delay elapsed without trip");

    minimum_delay_a: assert property (
        $rose(trip_q) && inverse_minimum_delay_mode |-> $past(dt_cnt_next) >= delay_q)
        else $error("inverse trip before minimum delay");

    force_off_a: assert property (
        !ctrl_q[`PST_CTRL_FORCE_EN] |=> start_o == ($past(state_q) == PST_STARTED) && trip_o == $past(trip_q))
        else $error("outputs differ from stage while not forced");

    early_release_a: assert property (
        eval_q && state_q == PST_STARTED && !pick_d |=> state_q == PST_IDLE && !trip_q && dt_cnt_q == '0)
        else $error("release did not clear timer");

    start_seen_c: cover property (go_start ##[1:300] trip_q);
    blocked_seen_c: cover property (blk_event ##1 evt_valid_o);
    inverse_trip_c: cover property (inverse_minimum_delay_mode && $rose(trip_q));
    release_seen_c: cover property (state_q == PST_STARTED ##1 state_q == PST_IDLE);

endmodule : pst_stage

`default_nettype wire

// *** pst_consts.svh ***
`ifndef PST_CONSTS_SVH
`define PST_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define PST_CLK_PERIOD_NS   100
`define PST_CYCLE_TIME_NS   1000000

// ****************************************
// Pick-up reset ratio, percent
// ****************************************
`define PST_RESET_PCT       7'd97
`define PST_FULL_PCT        7'd100

// ****************************************
// Register byte addresses
// ****************************************
`define PST_ADDR_CTRL       8'h00
`define PST_ADDR_PICKUP     8'h04
`define PST_ADDR_DELAY      8'h08
`define PST_ADDR_TDIAL      8'h0C
`define PST_ADDR_STATUS     8'h10
`define PST_ADDR_MASK       8'h14
`define PST_ADDR_STATE      8'h18

// ****************************************
// Control fields and reset values
// ****************************************
`define PST_CTRL_DTYPE      0
`define PST_CTRL_SERIES     1
`define PST_CTRL_FORCE_EN   2
`define PST_CTRL_F_START    3
`define PST_CTRL_F_TRIP     4
`define PST_CTRL_F_BLOCK    5
`define PST_CTRL_W          6
`define PST_CTRL_RST        6'h00

// ****************************************
// Status and mask fields
// ****************************************
`define PST_ST_START        0
`define PST_ST_TRIP         1
`define PST_ST_BLOCK        2
`define PST_ST_W            3

`endif

// *** pst_pkg.sv ***
package pst_pkg;

    // Stage condition
    typedef enum logic [1:0] {
        PST_IDLE    = 2'b00,
        PST_STARTED = 2'b01,
        PST_BLOCKED = 2'b10
    } pst_state_t;

    // Delay type selection
    typedef enum logic {
        PST_DEFINITE = 1'b0,
        PST_INVERSE  = 1'b1
    } pst_dtype_t;

    // Curve series selection
    typedef enum logic {
        PST_SER_IEC  = 1'b0,
        PST_SER_IEEE = 1'b1
    } pst_series_t;

endpackage : pst_pkg

// *** pst_front_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Measurement front end and blocking matrix
// ****************************************
module pst_front_model #(
    parameter int MAG_W = 16
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Values commanded by the bench
    input  wire logic [MAG_W-1:0] cmd_mag,
    input  wire logic [3:0]       cmd_fault,
    input  wire logic             cmd_block,
    // Toward the stage
    output logic      [MAG_W-1:0] measured_magnitude,
    output logic      [3:0]       fault_type,
    output logic                  block_in
);
    // Samples leave one clock after the command, like a converter output register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            measured_magnitude <= '0;
            fault_type         <= 4'h0;
            block_in           <= 1'b0;
        end else begin
            measured_magnitude <= cmd_mag;
            fault_type         <= cmd_fault;
            // Bench raises blocking whole processing cycles before the delay ends
            block_in           <= cmd_block;
        end
    end
endmodule : pst_front_model

`default_nettype wire

// *** test_protection_stage_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pst_consts.svh"

module test_protection_stage_timing;
    import pst_pkg::*;
    localparam int T = 8;
    logic        ref_clk, sys_rst, reg_wr, reg_rd, cmd_block, block_in;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, evt_time_o, rv, ev_time, ev_time1;
    longint      ev_at, ev_at1;
    logic [15:0] cmd_mag, measured_magnitude, evt_mag_o, ev_mag;
    logic [3:0]  cmd_fault, fault_type, evt_fault_o, ev_fault;
    logic        start_o, trip_o, blocked_o, irq_o, evt_valid_o;
    int          fails, check_count, ev_cnt, n, i;
    logic [31:0] iv_ctrl [3] = '{32'h1, 32'h1, 32'h3};
    logic [31:0] iv_dly  [3] = '{32'h0, 32'h6, 32'h0};
    int          iv_exp  [3] = '{2 * T, 5 * T, 4 * T};

    pst_stage #(.TICK_CYCLES(T)) u_pst_stage (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .measured_magnitude(measured_magnitude), .fault_type(fault_type), .block_in(block_in),
        .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .irq_o(irq_o), .evt_valid_o(evt_valid_o),
        .evt_time_o(evt_time_o), .evt_mag_o(evt_mag_o), .evt_fault_o(evt_fault_o));
    pst_front_model u_pst_front_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_mag(cmd_mag),
        .cmd_fault(cmd_fault), .cmd_block(cmd_block), .measured_magnitude(measured_magnitude),
        .fault_type(fault_type), .block_in(block_in));

    // ****************************************
    // Clock, event capture, watchdog
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Event pulse lasts one cycle, so it is caught here rather than polled
    always @(posedge ref_clk) begin
        if (evt_valid_o === 1'b1) begin
            ev_cnt   <= ev_cnt + 1;
            ev_mag   <= evt_mag_o;
            ev_fault <= evt_fault_o;
            ev_time  <= evt_time_o;
            ev_at    <= $time;
        end
    end

    // Tests need under 700 cycles; allow over thirty times that
    initial begin
        repeat (25000) @(posedge ref_clk);
        fails++;
        end_sim();
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32

    task automatic chkb(input string nm, input logic e, input logic g);
        chk32(nm, {31'h0, e}, {31'h0, g});
    endtask : chkb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic drv(input logic [15:0] m, input logic [3:0] f, input logic b);
        @(posedge ref_clk);
        cmd_mag   <= m;
        cmd_fault <= f;
        cmd_block <= b;
    endtask : drv

    task automatic ticks(input int k);
        repeat (k * T) @(posedge ref_clk);
        #1;
    endtask : ticks

    task automatic go_idle();
        drv(16'h0000, 4'h0, 1'b0);
        ticks(3);
    endtask : go_idle

    // Clocks from the rise of START to the rise of TRIP
    task automatic meas(output int c);
        int k;
        k = 0;
        while (start_o !== 1'b1 && k < 100) begin
            @(posedge ref_clk);
            #1 k++;
        end
        c = 0;
        while (trip_o !== 1'b1 && c < 400) begin
            @(posedge ref_clk);
            #1 c++;
        end
    endtask : meas

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {reg_wr, reg_rd, cmd_block, reg_addr, reg_wdata, cmd_mag, cmd_fault} = '0;
        {fails, check_count, ev_cnt} = '0;
        sys_rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`PST_ADDR_CTRL, rv);
        chk32("ctrl reset", 32'h0, rv);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, rv);
        chk32("unmapped", 32'h0, rv);
        wr(`PST_ADDR_STATE, 32'hFFFF_FFFF);
        rd(`PST_ADDR_STATE, rv);
        chk32("state ro", 32'h0, rv);
        $display("test registers done");
        wr(`PST_ADDR_MASK, 32'h3);
        wr(`PST_ADDR_PICKUP, 32'd100);
        wr(`PST_ADDR_DELAY, 32'd3);
        drv(16'd150, 4'h1, 1'b0);
        meas(n);
        chk32("definite delay", 3 * T - T, n);
        chkb("start", 1'b1, start_o);
        chkb("irq set", 1'b1, irq_o);
        rd(`PST_ADDR_STATUS, rv);
        chk32("status", 32'h3, rv);
        rd(`PST_ADDR_STATUS, rv);
        chk32("status cleared", 32'h0, rv);
        chkb("irq clear", 1'b0, irq_o);
        wr(`PST_ADDR_MASK, 32'h0);
        go_idle();
        $display("test definite done");
        wr(`PST_ADDR_DELAY, 32'd0);
        drv(16'd150, 4'h1, 1'b0);
        meas(n);
        chk32("instant delay", 32'd0, n);
        rd(`PST_ADDR_STATUS, rv);
        chk32("instant status", 32'h3, rv);
        go_idle();
        $display("test instant done");
        wr(`PST_ADDR_TDIAL, 32'd5);
        for (i = 0; i < 3; i++) begin
            wr(`PST_ADDR_CTRL, iv_ctrl[i]);
            wr(`PST_ADDR_DELAY, iv_dly[i]);
            drv(16'd200, 4'h1, 1'b0);
            meas(n);
            chk32("inverse delay", iv_exp[i], n);
            go_idle();
        end
        $display("test inverse done");
        wr(`PST_ADDR_CTRL, 32'h0);
        wr(`PST_ADDR_DELAY, 32'd20);
        drv(16'd101, 4'h1, 1'b0);
        ticks(3);
        chkb("pick above", 1'b1, start_o);
        drv(16'd97, 4'h1, 1'b0);
        ticks(3);
        chkb("hold at ratio", 1'b1, start_o);
        drv(16'd96, 4'h1, 1'b0);
        ticks(3);
        chkb("release", 1'b0, start_o);
        chkb("no trip", 1'b0, trip_o);
        go_idle();
        $display("test release done");
        drv(16'd150, 4'hA, 1'b1);
        ticks(4);
        chkb("blocked", 1'b1, blocked_o);
        chkb("blocked start", 1'b0, start_o);
        chk32("event count", 32'd1, ev_cnt);
        chk32("event mag", 32'd150, {16'h0, ev_mag});
        chk32("event fault", 32'hA, {28'h0, ev_fault});
        ev_time1 = ev_time;
        ev_at1   = ev_at;
        chkb("irq masked", 1'b0, irq_o);
        wr(`PST_ADDR_MASK, 32'h4);
        ticks(1);
        chkb("irq block", 1'b1, irq_o);
        rd(`PST_ADDR_STATUS, rv);
        chk32("status all", 32'h7, rv);
        go_idle();
        drv(16'd150, 4'h3, 1'b0);
        ticks(3);
        chkb("started", 1'b1, start_o);
        drv(16'd150, 4'h3, 1'b1);
        ticks(3);
        chkb("start cleared", 1'b0, start_o);
        chkb("trip held off", 1'b0, trip_o);
        chk32("event count 2", 32'd2, ev_cnt);
        chk32("event time", 32'((ev_at - ev_at1) / (`PST_CLK_PERIOD_NS * T)), ev_time - ev_time1);
        go_idle();
        $display("test blocking done");
        wr(`PST_ADDR_CTRL, 32'h10);
        ticks(1);
        chkb("force off", 1'b0, trip_o);
        wr(`PST_ADDR_CTRL, 32'h14);
        ticks(1);
        chkb("force on", 1'b1, trip_o);
        wr(`PST_ADDR_CTRL, 32'h2C);
        ticks(1);
        chkb("force start", 1'b1, start_o);
        chkb("force blocked", 1'b1, blocked_o);
        chkb("force trip off", 1'b0, trip_o);
        $display("test forcing done");
        end_sim();
    end
endmodule : test_protection_stage_timing

`default_nettype wire
